//--- dv/pin_board_model.sv
// Board-side model of the port pins: drivers, pull-ups and floating lines.
`timescale 1ns/1ns
// ======================================================================
// Pin level model
// ======================================================================
module pin_board_model
	import gpio_port_set_pkg::*;
(
	// Clock.
	input wire logic pclk,
	// Device side, ports packed E, D, C, B, A from the top.
	input wire logic [18:0] dev_out,
	input wire logic [18:0] dev_oe,
	input wire logic [18:0] dev_pu,
	// External drivers on the board.
	input wire logic [18:0] ext_en,
	input wire logic [18:0] ext_val,
	// Resolved pin levels.
	output logic [18:0] level
);
	logic float_reg = 1'b0;
	always @(posedge pclk)
	begin
		float_reg <= ~float_reg;
	end
	// A driven pin wins; a released pin is driven, pulled up or wanders.
	assign level = (dev_oe & dev_out)
		| (~dev_oe & ext_en & ext_val)
		| (~dev_oe & ~ext_en & dev_pu)
		| (~dev_oe & ~ext_en & {19{float_reg}});
endmodule : pin_board_model

//--- dv/tb_top.sv
// Self-checking bench of the five-port register and pin block.
`timescale 1ns/1ns
`include "gpio_port_set_defines.svh"
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))
// ======================================================================
// Bench top
// ======================================================================
module tb_top
	import gpio_port_set_pkg::*;
();
	localparam reg_index_type DIR_IDX [5] = '{`IDX_DIRECTION_PORT_A,
		`IDX_DIRECTION_PORT_B, `IDX_DIRECTION_PORT_C,
		`IDX_DIRECTION_PORT_D, `IDX_DIRECTION_PORT_E};
	localparam reg_index_type LAT_IDX [5] = '{`IDX_LATCH_PORT_A,
		`IDX_LATCH_PORT_B, `IDX_LATCH_PORT_C, `IDX_LATCH_PORT_D,
		`IDX_LATCH_PORT_E};
	localparam reg_index_type PU_IDX [5] = '{`IDX_PULLUP_PORT_A,
		`IDX_PULLUP_PORT_B, `IDX_PULLUP_PORT_C, 16'hFF36,
		`IDX_PULLUP_PORT_E};
	localparam reg_byte_type MASK [5] = '{8'h03, 8'hFF, 8'h0F, 8'h03, 8'h07};
	localparam reg_byte_type PU_MASK [5] = '{8'h03, 8'hFF, 8'h0F, 8'h00,
		8'h01};
	localparam int LSB [5] = '{0, 2, 10, 14, 16};
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rdata_q;
	logic [3:0] pstrb;
	logic err_q;
	logic [1:0] pin_out_a, pin_oe_a, pullup_en_a, pin_out_d, pin_oe_d;
	logic [7:0] pin_out_b, pin_oe_b, pullup_en_b;
	logic [3:0] pin_out_c, pin_oe_c, pullup_en_c;
	logic [2:0] pin_out_e, pin_oe_e;
	logic pullup_en_e, osc_takeover;
	logic [1:0] alt_drive_en_a, alt_drive_val_a;
	logic [7:0] alt_drive_en_b, alt_drive_val_b;
	logic [3:0] alt_drive_en_c, alt_drive_val_c;
	logic [18:0] level, ext_en, ext_val, all_out, all_oe, all_pu;
	int bad_count = 0;
	int samples_checked = 0;
	int exp_waits = 1;
	assign all_out = {pin_out_e, pin_out_d, pin_out_c, pin_out_b, pin_out_a};
	assign all_oe = {pin_oe_e, pin_oe_d, pin_oe_c, pin_oe_b, pin_oe_a};
	assign all_pu = {2'b00, pullup_en_e, 2'b00, pullup_en_c, pullup_en_b,
		pullup_en_a};
	general_purpose_port_set DUT
	(
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in_a(level[1:0]), .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a),
		.pullup_en_a(pullup_en_a), .pin_in_b(level[9:2]),
		.pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b), .pullup_en_b(pullup_en_b),
		.pin_in_c(level[13:10]), .pin_out_c(pin_out_c), .pin_oe_c(pin_oe_c),
		.pullup_en_c(pullup_en_c), .pin_in_d(level[15:14]),
		.pin_out_d(pin_out_d), .pin_oe_d(pin_oe_d), .pin_in_e(level[18:16]),
		.pin_out_e(pin_out_e), .pin_oe_e(pin_oe_e), .pullup_en_e(pullup_en_e),
		.alt_drive_en_a(alt_drive_en_a), .alt_drive_val_a(alt_drive_val_a),
		.alt_drive_en_b(alt_drive_en_b), .alt_drive_val_b(alt_drive_val_b),
		.alt_drive_en_c(alt_drive_en_c), .alt_drive_val_c(alt_drive_val_c),
		.osc_takeover(osc_takeover)
	);
	pin_board_model board
	(
		.pclk(pclk), .dev_out(all_out), .dev_oe(all_oe), .dev_pu(all_pu),
		.ext_en(ext_en), .ext_val(ext_val), .level(level)
	);
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;
	task automatic check_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : check_val
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	function automatic reg_byte_type port_bits(input logic [18:0] v,
		input int i);
		return 8'(v >> LSB[i]) & MASK[i];
	endfunction : port_bits
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input reg_index_type idx,
		input reg_byte_type wd, input logic [3:0] st);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		`CHK("bus waits", exp_waits, n);
		rdata_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input reg_index_type idx, input reg_byte_type d);
		apb(1'b1, idx, d, 4'hF);
	endtask : wr
	task automatic rd(input reg_index_type idx);
		apb(1'b0, idx, 8'h00, 4'h0);
	endtask : rd
	initial
	begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		$display("Watchdog expired");
		tally_and_finish();
	end
	initial
	begin
		reg_byte_type exp_v;
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{alt_drive_en_a, alt_drive_val_a, alt_drive_en_b} = '0;
		{alt_drive_val_b, alt_drive_en_c, alt_drive_val_c} = '0;
		ext_en = '1;
		ext_val = 19'h5A5C3;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		for (int i = 0; i < 5; i++)
		begin
			rd(DIR_IDX[i]);
			`CHK("direction reset", 8'hFF, rdata_q);
			rd(LAT_IDX[i]);
			`CHK("input read", port_bits(ext_val, i), rdata_q);
			rd(PU_IDX[i]);
			`CHK("pull-up reset", 8'h00, rdata_q);
		end
		`CHK("enables after reset", 19'h0, all_oe);
		$display("Test reset values done");
		for (int i = 0; i < 5; i++)
		begin
			wr(DIR_IDX[i], 8'hA5);
			rd(DIR_IDX[i]);
			`CHK("direction", 8'(8'hA5 | ~MASK[i]), rdata_q);
			@(negedge pclk);
			`CHK("enables", ~8'hA5 & MASK[i], port_bits(all_oe, i));
			`CHK("values", 8'h00, port_bits(all_out, i));
		end
		$display("Test direction done");
		for (int i = 0; i < 5; i++)
		begin
			wr(DIR_IDX[i], 8'hFF);
			wr(LAT_IDX[i], 8'h69);
			@(negedge pclk);
			`CHK("input enables", 8'h00, port_bits(all_oe, i));
			wr(DIR_IDX[i], 8'h00);
			rd(LAT_IDX[i]);
			`CHK("latch read", 8'h69 & MASK[i], rdata_q);
			exp_v = i == 3 ? 8'h00 : 8'h69 & MASK[i];
			`CHK("pin values", exp_v, port_bits(all_out, i));
			exp_v = i == 3 ? ~8'h69 & MASK[i] : MASK[i];
			`CHK("pin enables", exp_v, port_bits(all_oe, i));
		end
		`CHK("all enables", 19'h7BFFF, all_oe);
		$display("Test latches done");
		rd(DIR_IDX[1]);
		wr(DIR_IDX[1], rdata_q[7:0] | 8'h08);
		apb(1'b1, DIR_IDX[1], 8'hFF, 4'hE);
		rd(DIR_IDX[1]);
		`CHK("bit update", 8'h08, rdata_q);
		`CHK("bit update pins", 8'hF7, pin_oe_b);
		$display("Test single bit update done");
		ext_en <= '0;
		for (int i = 0; i < 5; i++)
		begin
			wr(DIR_IDX[i], 8'hFF);
			wr(PU_IDX[i], 8'hFF);
			`CHK("pull-up error", i == 3, err_q);
			rd(PU_IDX[i]);
			`CHK("pull-up read", PU_MASK[i], rdata_q);
		end
		`CHK("pull-ups on", 19'h13FFF, all_pu);
		repeat (6) @(posedge pclk);
		for (int i = 0; i < 3; i++)
		begin
			rd(LAT_IDX[i]);
			`CHK("pulled input", MASK[i], rdata_q);
		end
		{alt_drive_en_a, alt_drive_val_a} <= {2'b11, 2'b10};
		{alt_drive_en_b, alt_drive_val_b} <= {8'hFF, 8'h5A};
		{alt_drive_en_c, alt_drive_val_c} <= {4'hF, 4'h6};
		@(negedge pclk);
		`CHK("alternate pull-ups", 19'h10000, all_pu);
		for (int i = 0; i < 5; i++)
			wr(DIR_IDX[i], 8'h00);
		@(negedge pclk);
		`CHK("output pull-ups", 19'h0, all_pu);
		`CHK("alternate values", {4'h6, 8'h5A, 2'b10}, all_out[13:0]);
		{alt_drive_en_a, alt_drive_en_b, alt_drive_en_c} <= '0;
		$display("Test pull-ups done");
		wr(LAT_IDX[4], 8'h07);
		for (int k = 0; k < 3; k++)
		begin
			wr(`IDX_OSCILLATOR_MODE, k == 2 ? 8'h00 : 8'(k + 1));
			@(negedge pclk);
			`CHK("takeover", k < 2, osc_takeover);
			`CHK("port e enables", k < 2 ? 3'b001 : 3'b111, pin_oe_e);
			`CHK("port e values", k < 2 ? 3'b001 : 3'b111, pin_out_e);
		end
		$display("Test oscillator takeover done");
		rd(16'h0100);
		`CHK("unmapped error", 1'b1, err_q);
		`CHK("unmapped data", 32'h0, rdata_q);
		exp_waits = 4;
		fork
			rd(DIR_IDX[0]);
			begin
				repeat (2) @(posedge pclk);
				clk_en <= 1'b0;
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		`CHK("stalled read", 8'hFC, rdata_q);
		$display("Test bus access done");
		tally_and_finish();
	end
endmodule : tb_top

//--- shared/gpio_port_set_defines.svh
// Register indices, field positions and reset values of the port set.
`ifndef GPIO_PORT_SET_DEFINES_SVH
`define GPIO_PORT_SET_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define IDX_LATCH_PORT_A 16'hFF00
`define IDX_LATCH_PORT_B 16'hFF01
`define IDX_LATCH_PORT_C 16'hFF03
`define IDX_LATCH_PORT_D 16'hFF06
`define IDX_LATCH_PORT_E 16'hFF0C
`define IDX_DIRECTION_PORT_A 16'hFF20
`define IDX_DIRECTION_PORT_B 16'hFF21
`define IDX_DIRECTION_PORT_C 16'hFF23
`define IDX_DIRECTION_PORT_D 16'hFF26
`define IDX_DIRECTION_PORT_E 16'hFF2C
`define IDX_PULLUP_PORT_A 16'hFF30
`define IDX_PULLUP_PORT_B 16'hFF31
`define IDX_PULLUP_PORT_C 16'hFF33
`define IDX_PULLUP_PORT_E 16'hFF3C
`define IDX_OSCILLATOR_MODE 16'hFF40

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_DIRECTION 8'hFF
`define RST_LATCH 8'h00
`define RST_PULLUP 8'h00
`define RST_OSCILLATOR_MODE 8'h00

// ==========================================================================
// Oscillator mode field positions
// ==========================================================================
`define OSC_RESONATOR_BIT 0
`define OSC_EXT_CLOCK_BIT 1

`endif

//--- shared/gpio_port_set_pkg.sv
// Types shared by the port set design.
package gpio_port_set_pkg;

	// ======================================================================
	// Types
	// ======================================================================
	typedef logic [7:0] reg_byte_type;
	typedef logic [15:0] reg_index_type;

endpackage : gpio_port_set_pkg

//--- verilog/general_purpose_port_set.sv
// APB register block and pin logic of five general-purpose ports.
`timescale 1ns/1ns
`include "gpio_port_set_defines.svh"

module general_purpose_port_set
	import gpio_port_set_pkg::*;
#(
	parameter int ADDR_W = 18
)
(
	// Clock, reset and clock enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A pins.
	input wire logic [1:0] pin_in_a,
	output logic [1:0] pin_out_a,
	output logic [1:0] pin_oe_a,
	output logic [1:0] pullup_en_a,
	// Port B pins.
	input wire logic [7:0] pin_in_b,
	output logic [7:0] pin_out_b,
	output logic [7:0] pin_oe_b,
	output logic [7:0] pullup_en_b,
	// Port C pins.
	input wire logic [3:0] pin_in_c,
	output logic [3:0] pin_out_c,
	output logic [3:0] pin_oe_c,
	output logic [3:0] pullup_en_c,
	// Port D open-drain pins.
	input wire logic [1:0] pin_in_d,
	output logic [1:0] pin_out_d,
	output logic [1:0] pin_oe_d,
	// Port E pins.
	input wire logic [2:0] pin_in_e,
	output logic [2:0] pin_out_e,
	output logic [2:0] pin_oe_e,
	output logic pullup_en_e,
	// Alternate-function outputs of the shared peripherals.
	input wire logic [1:0] alt_drive_en_a,
	input wire logic [1:0] alt_drive_val_a,
	input wire logic [7:0] alt_drive_en_b,
	input wire logic [7:0] alt_drive_val_b,
	input wire logic [3:0] alt_drive_en_c,
	input wire logic [3:0] alt_drive_val_c,
	// Oscillator takeover of port E bits 1 and 2.
	output logic osc_takeover
);
	default disable iff (!presetn);

	// ======================================================================
	// Functions
	// ======================================================================
	function automatic reg_byte_type merge_read(input reg_byte_type dir,
		input reg_byte_type latch, input reg_byte_type pin);
		merge_read = (dir & pin) | (~dir & latch);
	endfunction : merge_read

	function automatic logic [18:0] agree_filter(input logic [18:0] s2,
		input logic [18:0] s3, input logic [18:0] held);
		agree_filter = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & held);
	endfunction : agree_filter

	// ======================================================================
	// Registers
	// ======================================================================
	logic [1:0] dir_a_reg;
	logic [7:0] dir_b_reg;
	logic [3:0] dir_c_reg;
	logic [1:0] dir_d_reg;
	logic [2:0] dir_e_reg;
	logic [1:0] latch_a_reg;
	logic [7:0] latch_b_reg;
	logic [3:0] latch_c_reg;
	logic [1:0] latch_d_reg;
	logic [2:0] latch_e_reg;
	logic [1:0] pullup_a_reg;
	logic [7:0] pullup_b_reg;
	logic [3:0] pullup_c_reg;
	logic pullup_e_reg;
	logic [7:0] osc_mode_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [18:0] sync1_reg;
	logic [18:0] sync2_reg;
	logic [18:0] sync3_reg;
	logic [18:0] pins_reg;
	logic [18:0] pins_next;

	// ======================================================================
	// Address decode
	// ======================================================================
	wire reg_index_type index = paddr[17:2];
	wire aligned = (paddr[1:0] == 2'h0);
	wire hit_latch_a = aligned && (index == `IDX_LATCH_PORT_A);
	wire hit_latch_b = aligned && (index == `IDX_LATCH_PORT_B);
	wire hit_latch_c = aligned && (index == `IDX_LATCH_PORT_C);
	wire hit_latch_d = aligned && (index == `IDX_LATCH_PORT_D);
	wire hit_latch_e = aligned && (index == `IDX_LATCH_PORT_E);
	wire hit_dir_a = aligned && (index == `IDX_DIRECTION_PORT_A);
	wire hit_dir_b = aligned && (index == `IDX_DIRECTION_PORT_B);
	wire hit_dir_c = aligned && (index == `IDX_DIRECTION_PORT_C);
	wire hit_dir_d = aligned && (index == `IDX_DIRECTION_PORT_D);
	wire hit_dir_e = aligned && (index == `IDX_DIRECTION_PORT_E);
	wire hit_pu_a = aligned && (index == `IDX_PULLUP_PORT_A);
	wire hit_pu_b = aligned && (index == `IDX_PULLUP_PORT_B);
	wire hit_pu_c = aligned && (index == `IDX_PULLUP_PORT_C);
	wire hit_pu_e = aligned && (index == `IDX_PULLUP_PORT_E);
	wire hit_osc = aligned && (index == `IDX_OSCILLATOR_MODE);
	wire hit_any = hit_latch_a | hit_latch_b | hit_latch_c | hit_latch_d |
		hit_latch_e | hit_dir_a | hit_dir_b | hit_dir_c | hit_dir_d |
		hit_dir_e | hit_pu_a | hit_pu_b | hit_pu_c | hit_pu_e | hit_osc;

	wire access = psel && penable && clk_en;
	wire setup = psel && !penable && clk_en;
	wire wr_byte = access && pwrite && pstrb[0];
	wire reg_byte_type wdat = pwdata[7:0];

	assign pready = clk_en;
	assign pslverr = psel && penable && !hit_any;
	assign prdata = prdata_reg;

	// ======================================================================
	// Pin input synchroniser
	// ======================================================================
	wire [18:0] pins_raw = {pin_in_e, pin_in_d, pin_in_c, pin_in_b,
		pin_in_a};
	assign pins_next = agree_filter(sync2_reg, sync3_reg, pins_reg);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 19'h0;
			sync2_reg <= 19'h0;
			sync3_reg <= 19'h0;
			pins_reg <= 19'h0;
		end
		else if (clk_en)
		begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pins_reg <= pins_next;
		end
	end

	wire [1:0] pins_a = pins_reg[1:0];
	wire [7:0] pins_b = pins_reg[9:2];
	wire [3:0] pins_c = pins_reg[13:10];
	wire [1:0] pins_d = pins_reg[15:14];
	wire [2:0] pins_e = pins_reg[18:16];

	// ======================================================================
	// Direction, latch, pull-up and oscillator mode registers
	// ======================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dir_a_reg <= 2'h3;
			dir_b_reg <= `RST_DIRECTION;
			dir_c_reg <= 4'hF;
			dir_d_reg <= 2'h3;
			dir_e_reg <= 3'h7;
		end
		else
		begin
			if (wr_byte && hit_dir_a)
				dir_a_reg <= wdat[1:0];
			if (wr_byte && hit_dir_b)
				dir_b_reg <= wdat;
			if (wr_byte && hit_dir_c)
				dir_c_reg <= wdat[3:0];
			if (wr_byte && hit_dir_d)
				dir_d_reg <= wdat[1:0];
			if (wr_byte && hit_dir_e)
				dir_e_reg <= wdat[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			latch_a_reg <= 2'h0;
			latch_b_reg <= `RST_LATCH;
			latch_c_reg <= 4'h0;
			latch_d_reg <= 2'h0;
			latch_e_reg <= 3'h0;
		end
		else
		begin
			if (wr_byte && hit_latch_a)
				latch_a_reg <= wdat[1:0];
			if (wr_byte && hit_latch_b)
				latch_b_reg <= wdat;
			if (wr_byte && hit_latch_c)
				latch_c_reg <= wdat[3:0];
			if (wr_byte && hit_latch_d)
				latch_d_reg <= wdat[1:0];
			if (wr_byte && hit_latch_e)
				latch_e_reg <= wdat[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pullup_a_reg <= 2'h0;
			pullup_b_reg <= `RST_PULLUP;
			pullup_c_reg <= 4'h0;
			pullup_e_reg <= 1'b0;
			osc_mode_reg <= `RST_OSCILLATOR_MODE;
		end
		else
		begin
			if (wr_byte && hit_pu_a)
				pullup_a_reg <= wdat[1:0];
			if (wr_byte && hit_pu_b)
				pullup_b_reg <= wdat;
			if (wr_byte && hit_pu_c)
				pullup_c_reg <= wdat[3:0];
			if (wr_byte && hit_pu_e)
				pullup_e_reg <= wdat[0];
			if (wr_byte && hit_osc)
				osc_mode_reg <= wdat;
		end
	end

	// ======================================================================
	// Read path
	// ======================================================================
	wire reg_byte_type rd_latch_a = merge_read({6'h3F, dir_a_reg},
		{6'h0, latch_a_reg}, {6'h0, pins_a}) & 8'h03;
	wire reg_byte_type rd_latch_b = merge_read(dir_b_reg, latch_b_reg,
		pins_b);
	wire reg_byte_type rd_latch_c = merge_read({4'hF, dir_c_reg},
		{4'h0, latch_c_reg}, {4'h0, pins_c}) & 8'h0F;
	wire reg_byte_type rd_latch_d = merge_read({6'h3F, dir_d_reg},
		{6'h0, latch_d_reg}, {6'h0, pins_d}) & 8'h03;
	wire reg_byte_type rd_latch_e = merge_read({5'h1F, dir_e_reg},
		{5'h0, latch_e_reg}, {5'h0, pins_e}) & 8'h07;

	// Unused direction bits read as one and leave every pin an input.
	wire reg_byte_type rd_data =
		hit_latch_a ? rd_latch_a :
		hit_latch_b ? rd_latch_b :
		hit_latch_c ? rd_latch_c :
		hit_latch_d ? rd_latch_d :
		hit_latch_e ? rd_latch_e :
		hit_dir_a ? {6'h3F, dir_a_reg} :
		hit_dir_b ? dir_b_reg :
		hit_dir_c ? {4'hF, dir_c_reg} :
		hit_dir_d ? {6'h3F, dir_d_reg} :
		hit_dir_e ? {5'h1F, dir_e_reg} :
		hit_pu_a ? {6'h0, pullup_a_reg} :
		hit_pu_b ? pullup_b_reg :
		hit_pu_c ? {4'h0, pullup_c_reg} :
		hit_pu_e ? {7'h0, pullup_e_reg} :
		hit_osc ? osc_mode_reg :
		8'h00;

	assign prdata_next = (setup && !pwrite) ? {24'h0, rd_data} : prdata_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0;
		else
			prdata_reg <= prdata_next;
	end

	// ======================================================================
	// Pin drive
	// ======================================================================
	assign osc_takeover = osc_mode_reg[`OSC_RESONATOR_BIT] |
		osc_mode_reg[`OSC_EXT_CLOCK_BIT];

	// Fourteen push-pull pins drive whenever their direction bit is zero.
	assign pin_oe_a = ~dir_a_reg;
	assign pin_out_a = (alt_drive_en_a & alt_drive_val_a) |
		(~alt_drive_en_a & latch_a_reg);
	assign pin_oe_b = ~dir_b_reg;
	assign pin_out_b = (alt_drive_en_b & alt_drive_val_b) |
		(~alt_drive_en_b & latch_b_reg);
	assign pin_oe_c = ~dir_c_reg;
	assign pin_out_c = (alt_drive_en_c & alt_drive_val_c) |
		(~alt_drive_en_c & latch_c_reg);

	// Port D only ever pulls low.
	assign pin_out_d = 2'h0;
	assign pin_oe_d = ~dir_d_reg & ~latch_d_reg;

	// The oscillator owns E1 and E2 in resonator or external clock mode.
	assign pin_oe_e = {~dir_e_reg[2:1] & {2{~osc_takeover}},
		~dir_e_reg[0]};
	assign pin_out_e = latch_e_reg & {~osc_takeover, ~osc_takeover, 1'b1};

	// Pull-ups only while the pin is an input and not an alternate output.
	assign pullup_en_a = pullup_a_reg & dir_a_reg & ~alt_drive_en_a;
	assign pullup_en_b = pullup_b_reg & dir_b_reg & ~alt_drive_en_b;
	assign pullup_en_c = pullup_c_reg & dir_c_reg & ~alt_drive_en_c;
	assign pullup_en_e = pullup_e_reg & dir_e_reg[0];

	// ======================================================================
	// Assertions
	// ======================================================================
	logic released_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			released_reg <= 1'b0;
		else
			released_reg <= 1'b1;
	end

	AST_DIR_A_WRITE: assert property (@(posedge pclk)
		(wr_byte && hit_dir_a) |=> (dir_a_reg == $past(pwdata[1:0])))
		else $error("direction A did not take the written value");

	AST_LATCH_B_TO_PIN: assert property (@(posedge pclk)
		(wr_byte && hit_latch_b && (alt_drive_en_b == 8'h00)) |=>
		(pin_out_b == $past(pwdata[7:0])) &&
		(pin_oe_b == ~$past(dir_b_reg)))
		else $error("port B latch write not seen on the pins");

	AST_DIR_C_READ_ONES: assert property (@(posedge pclk)
		(setup && !pwrite && hit_dir_c) |=> (prdata[7:4] == 4'hF))
		else $error("unused direction C bits did not read as one");

	AST_PORT_D_OPEN_DRAIN: assert property (@(posedge pclk)
		(pin_out_d == 2'h0) && ((pin_oe_d & latch_d_reg) == 2'h0))
		else $error("port D drove high or drove with latch one");

	AST_RESET_INPUTS: assert property (@(posedge pclk)
		!released_reg |-> (pin_oe_a == 2'h0) && (pin_oe_b == 8'h00) &&
		(pin_oe_c == 4'h0) && (pin_oe_d == 2'h0) && (pin_oe_e == 3'h0))
		else $error("a pin drove right after reset");

	AST_OSC_TAKEOVER: assert property (@(posedge pclk)
		(wr_byte && hit_osc && (pwdata[1:0] != 2'h0)) |=>
		osc_takeover && (pin_oe_e[2:1] == 2'h0))
		else $error("oscillator mode did not release E1 and E2");

	AST_PULLUP_OFF_OUTPUT: assert property (@(posedge pclk)
		((pullup_en_b & ~dir_b_reg) == 8'h00) &&
		((pullup_en_c & alt_drive_en_c) == 4'h0) &&
		!(pullup_en_e && !dir_e_reg[0]))
		else $error("pull-up connected to a driving pin");

	AST_READ_MERGE: assert property (@(posedge pclk)
		(setup && !pwrite && hit_latch_b) |=>
		(prdata[7:0] == (($past(dir_b_reg) & $past(pins_b)) |
		(~$past(dir_b_reg) & $past(latch_b_reg)))))
		else $error("port B read did not merge pins and latch");

	AST_INPUT_WRITE_NO_PIN: assert property (@(posedge pclk)
		(wr_byte && hit_latch_a && (dir_a_reg == 2'h3)) |=>
		(pin_oe_a == 2'h0) && (latch_a_reg == $past(pwdata[1:0])))
		else $error("latch write in input mode disturbed port A");

endmodule : general_purpose_port_set
